// [src/mmnp_pkg.sv]
// Shared constants and types of the memory map and nonvolatile protection block.
// Assumes one 20 MHz system clock and an 8-bit core data bus with a 12-bit program bus.
// Behaviour
// R1: Ports, peripherals, core registers live in data space.
// R2: 0x00-0x3F is SRAM, 0x40-0x7F data EEPROM.
// R3: Core registers sit at fixed data addresses.
// R4: Program storage 0x800-0xFF5, vectors up to 0xFFF.
// R5: Program EEPROM is read only in normal mode.
// R6: Program rewrites need programming mode and no write lock.
// R7: Software polls ready flag before data EEPROM store.
// R8: Ready flag is 1 idle, 0 while writing.
// R9: EEPROM sets ready flag itself after write.
// R10: Software avoids EEPROM access while busy.
// R11: Two init registers load at power-up.
// R12: Second init register drives oscillator trim.
// R13: Init registers readable and writable in programming mode.
// R14: Clock mode from bits 7 and 6.
// R15: Read lock refuses reads in programming mode.
// R16: Write lock refuses writes in programming mode.
// R17: Upper-block lock blocks writes to 0x60-0x7F.
// R18: Rewriters keep brown-out level bit unchanged.
// R19: Brown-out enable permits brown-out reset.
// R20: Watchdog enable bit enables the watchdog.
// R21: Both locks set refuse programming mode entry.
// R22: Without write lock, locks may be cleared.
// R23: Reserved addresses read zero, ignore writes.
package mmnp_pkg;

	// Data space layout
	localparam logic [7:0]  SRAM_LAST      = 8'h3F;   // Scratch RAM end
	localparam logic [7:0]  EE_FIRST       = 8'h40;   // Data EEPROM start
	localparam logic [7:0]  EE_LAST        = 8'h7F;   // Data EEPROM end
	localparam logic [7:0]  EE_UPPER_FIRST = 8'h60;   // Lockable upper block
	localparam logic [7:0]  CONV_FIRST     = 8'h9D;   // Converter registers
	localparam logic [7:0]  CONV_LAST      = 8'h9F;
	localparam logic [7:0]  TMR1_FIRST     = 8'hAA;   // Timer1 up to halt control
	localparam logic [7:0]  HALT_CTRL      = 8'hB7;   // Halt-control register
	localparam logic [7:0]  IDX_HIGH       = 8'hBE;   // Core registers
	localparam logic [7:0]  IDX_LOW        = 8'hBF;
	localparam logic [7:0]  PWR_MODE_CLR   = 8'hC0;
	localparam logic [7:0]  STACK_PTR      = 8'hCE;
	localparam logic [7:0]  PROC_STATUS    = 8'hCF;

	// Program space layout
	localparam logic [11:0] CODE_FIRST     = 12'h800; // Code EEPROM start
	localparam logic [11:0] CODE_LAST      = 12'hFF5; // Code EEPROM end
	localparam logic [11:0] VEC_ADC        = 12'hFFE; // Converter vector
	localparam logic [11:0] INIT1_PADDR    = 12'h000; // Init register 1 in programming mode
	localparam logic [11:0] INIT2_PADDR    = 12'h001; // Init register 2 in programming mode

	// Status register fields
	localparam int          SR_READY_BIT   = 6;       // Data EEPROM ready flag
	localparam logic [7:0]  SR_RESET       = 8'h40;   // Ready set, rest clear

	// Factory contents of the init registers
	localparam logic [7:0]  INIT1_FACTORY  = 8'h08;   // Level select set
	localparam logic [7:0]  INIT2_FACTORY  = 8'h80;   // Mid-scale trim

	// Data EEPROM write time and derived cycles (least time, rounded up)
	localparam int          CLK_PERIOD_NS  = 50;
	localparam int          EE_WRITE_NS    = 2000000;
	localparam int          EE_WRITE_CYC   = (EE_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// First init register, bit 7 down to bit 0
	typedef struct packed {
		logic clkSel0;        // Bit 7
		logic clkSel1;        // Bit 6
		logic watchdogEn;     // Bit 5
		logic brownoutEn;     // Bit 4
		logic brownoutLvl;    // Bit 3
		logic upperLock;      // Bit 2
		logic writeLock;      // Bit 1
		logic readLock;       // Bit 0
	} mmnp_init1_t;

	// Core data bus request
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} mmnp_dreq_t;

	// Program bus request
	typedef struct packed {
		logic        rd;
		logic        wr;
		logic [11:0] addr;
		logic [7:0]  wdata;
	} mmnp_preq_t;

	// Data space regions
	typedef enum logic [2:0] {
		RG_SRAM, RG_EE, RG_PERIPH, RG_CORE, RG_RSVD
	} mmnp_region_t;

	// Power-up sequence
	typedef enum logic [2:0] {
		ST_FETCH1 = 3'b001,
		ST_FETCH2 = 3'b010,
		ST_RUN    = 3'b100
	} mmnp_state_t;

endpackage : mmnp_pkg

// [src/mmnp_byte_mem.sv]
// Byte-wide flip-flop storage with one write and one combinational read port.
// Assumes the caller decodes and qualifies the write strobe.
`timescale 1ns/1ps
module mmnp_byte_mem #(
	parameter int DEPTH = 64,
	parameter int AW    = 6
) (
	// Clock
	input  wire logic          clk,
	// Write side
	input  wire logic          wrEn,
	input  wire logic [AW-1:0] wrAddr,
	input  wire logic [7:0]    wrData,
	// Read side
	input  wire logic [AW-1:0] rdAddr,
	output logic      [7:0]    rdData
);
	import mmnp_pkg::*;

	logic [7:0] mem [DEPTH];   // Storage cells, not reset

	// Store on strobe
	always_ff @(posedge clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
	end

	// Read by index
	assign rdData = mem[rdAddr];

endmodule : mmnp_byte_mem

// [src/mmnp_ee_timer.sv]
// Data EEPROM write-cycle timer producing the ready flag.
// Assumes start only arrives while ready is high.
`timescale 1ns/1ps
module mmnp_ee_timer #(
	parameter int CYCLES = 40000
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control
	input  wire logic start,
	output logic      ready
);
	import mmnp_pkg::*;

	logic [31:0] count_q;   // Remaining busy cycles

	// Busy count; ready returns by itself at the end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count_q <= 32'h0000_0000;
		end else if (start) begin
			count_q <= 32'(CYCLES);
		end else if (count_q != 32'h0000_0000) begin
			count_q <= count_q - 32'h0000_0001;   // [R9]
		end
	end

	// Ready flag as a flop
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ready <= 1'b1;
		end else begin
			ready <= !start && (count_q <= 32'h0000_0001);   // [R8]
		end
	end

endmodule : mmnp_ee_timer

// [src/mmnp_top.sv]
// Data and program address decode with data EEPROM handshake and init-register protection.
// Assumes the core issues one data request and one program request per cycle at most,
// and that peripherals answer reads combinationally in the cycle their strobe is high.
`timescale 1ns/1ps
module mmnp_top #(
	parameter int EE_WRITE_CYCLES = mmnp_pkg::EE_WRITE_CYC
) (
	// Clock and reset
	input  wire logic                     ref_clk,
	input  wire logic                     rst,
	// Core data bus
	input  wire mmnp_pkg::mmnp_dreq_t     dataReq,
	output logic                          dataRdValid,
	output logic      [7:0]               dataRdData,
	// Peripheral register strobes
	output logic                          periphRd,
	output logic                          periphWr,
	output logic      [7:0]               periphAddr,
	output logic      [7:0]               periphWData,
	input  wire logic [7:0]               periphRdData,
	// Program bus
	input  wire mmnp_pkg::mmnp_preq_t     progReq,
	output logic                          progRdValid,
	output logic      [7:0]               progRdData,
	// Pins
	input  wire logic                     progModePin,
	input  wire logic                     supplyLowPin,
	// Mode and configuration
	output logic                          progModeActive,
	output logic                          configValid,
	output logic      [1:0]               clockModeSel,
	output logic                          watchdogEnable,
	output logic                          brownoutEnable,
	output logic                          brownoutLevelSelect,
	output logic                          brownoutReset,
	output logic      [7:0]               oscTrim
);
	import mmnp_pkg::*;

	// Synchronisers for pins
	logic        progPinS1_q;      // First stage, read by second only
	logic        progPinS2_q;
	logic        supplyS1_q;
	logic        supplyS2_q;

	// Power-up sequencer and configuration
	mmnp_state_t state_q;
	mmnp_init1_t nvInit1_q;        // Stored first init word
	logic [7:0]  nvInit2_q;        // Stored trim word
	mmnp_init1_t cfg_q;            // Live copy
	logic [7:0]  trim_q;
	logic        progMode_q;

	// Core registers
	logic [7:0]  idxHigh_q;
	logic [7:0]  idxLow_q;
	logic [7:0]  pwrModeClr_q;
	logic [7:0]  stackPtr_q;
	logic [7:0]  status_q;         // Ready bit kept apart

	// Read pipeline
	mmnp_dreq_t  dReq_q;           // Request taken, stage one
	mmnp_region_t dRegion;
	mmnp_region_t dRegionQ;

	// Memory ports
	logic [7:0]  sramRd;
	logic [7:0]  eeRd;
	logic [7:0]  codeRd;
	logic        sramWr;
	logic        eeAccept;
	logic        eeReady;
	logic        upperBlocked;
	logic        progMemWr;
	logic        initWrAllowed;

	// Region of a data address
	function automatic mmnp_region_t decodeData(input logic [7:0] a);
		if (a <= SRAM_LAST) begin
			decodeData = RG_SRAM;
		end else if (a >= EE_FIRST && a <= EE_LAST) begin
			decodeData = RG_EE;
		end else if ((a >= CONV_FIRST && a <= CONV_LAST) || (a >= TMR1_FIRST && a <= HALT_CTRL)) begin
			decodeData = RG_PERIPH;
		end else if (a == IDX_HIGH || a == IDX_LOW || a == PWR_MODE_CLR || a == STACK_PTR
		             || a == PROC_STATUS) begin
			decodeData = RG_CORE;
		end else begin
			decodeData = RG_RSVD;
		end
	endfunction : decodeData

	// Two-flop pin synchronisers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			progPinS1_q <= 1'b0;
			progPinS2_q <= 1'b0;
			supplyS1_q  <= 1'b0;
			supplyS2_q  <= 1'b0;
		end else begin
			progPinS1_q <= progModePin;
			progPinS2_q <= progPinS1_q;
			supplyS1_q  <= supplyLowPin;
			supplyS2_q  <= supplyS1_q;
		end
	end

	// Data address decode
	assign dRegion  = decodeData(dataReq.addr);   // [R1] [R2] [R3]
	assign dRegionQ = decodeData(dReq_q.addr);

	// Data write qualifiers
	assign sramWr       = dataReq.wr && dRegion == RG_SRAM && state_q == ST_RUN;
	assign upperBlocked = cfg_q.upperLock && dataReq.addr >= EE_UPPER_FIRST;   // [R17]
	assign eeAccept     = dataReq.wr && dRegion == RG_EE && eeReady && !upperBlocked
	                      && state_q == ST_RUN;   // Busy writes dropped

	// Program write qualifiers
	assign initWrAllowed = progMode_q && !cfg_q.writeLock;   // [R16] [R22]
	assign progMemWr     = progReq.wr && progReq.addr >= CODE_FIRST && initWrAllowed;   // [R5] [R6]

	// Scratch RAM
	mmnp_byte_mem #(.DEPTH(64), .AW(6)) uSram (
		.clk    (ref_clk),
		.wrEn   (sramWr),
		.wrAddr (dataReq.addr[5:0]),
		.wrData (dataReq.wdata),
		.rdAddr (dReq_q.addr[5:0]),
		.rdData (sramRd)
	);

	// Data EEPROM array
	mmnp_byte_mem #(.DEPTH(64), .AW(6)) uEeArray (
		.clk    (ref_clk),
		.wrEn   (eeAccept),
		.wrAddr (dataReq.addr[5:0]),
		.wrData (dataReq.wdata),
		.rdAddr (dReq_q.addr[5:0]),
		.rdData (eeRd)
	);

	// Code EEPROM with vectors, 0x800 to 0xFFF
	mmnp_byte_mem #(.DEPTH(2048), .AW(11)) uCode (
		.clk    (ref_clk),
		.wrEn   (progMemWr),
		.wrAddr (progReq.addr[10:0]),
		.wrData (progReq.wdata),
		.rdAddr (progReq.addr[10:0]),
		.rdData (codeRd)
	);

	// Data EEPROM write timer
	mmnp_ee_timer #(.CYCLES(EE_WRITE_CYCLES)) uEeTimer (
		.clk   (ref_clk),
		.rst   (rst),
		.start (eeAccept),
		.ready (eeReady)
	);

	// Power-up fetch of both init registers
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state_q <= ST_FETCH1;
		end else begin
			unique case (state_q)
				ST_FETCH1: begin
					state_q <= ST_FETCH2;   // [R11]
				end
				ST_FETCH2: begin
					state_q <= ST_RUN;
				end
				ST_RUN: begin
					state_q <= (progMode_q && !progPinS2_q) ? ST_FETCH1 : ST_RUN;   // Leaving programming mode refetches
				end
				default: begin
					state_q <= ST_FETCH1;
				end
			endcase
		end
	end

	// Live configuration copies
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_q  <= mmnp_init1_t'(8'h00);
			trim_q <= 8'h00;
		end else if (state_q == ST_FETCH1) begin
			cfg_q <= nvInit1_q;   // [R11]
		end else if (state_q == ST_FETCH2) begin
			trim_q <= nvInit2_q;  // [R12]
		end
	end

	// Stored init words, rewritable in programming mode
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			nvInit1_q <= mmnp_init1_t'(INIT1_FACTORY);
			nvInit2_q <= INIT2_FACTORY;
		end else if (progReq.wr && initWrAllowed) begin
			if (progReq.addr == INIT1_PADDR) begin
				nvInit1_q <= mmnp_init1_t'(progReq.wdata);   // [R13] [R22]
			end
			if (progReq.addr == INIT2_PADDR) begin
				nvInit2_q <= progReq.wdata;   // [R13]
			end
		end
	end

	// Programming mode entry and exit
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			progMode_q <= 1'b0;
		end else if (!progPinS2_q) begin
			progMode_q <= 1'b0;
		end else if (state_q == ST_RUN && !(cfg_q.readLock && cfg_q.writeLock)) begin
			progMode_q <= 1'b1;   // [R21]
		end
	end

	// Program read answer, one cycle after the request
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			progRdValid <= 1'b0;
			progRdData  <= 8'h00;
		end else begin
			progRdValid <= progReq.rd;
			if (!progReq.rd || (progMode_q && cfg_q.readLock)) begin
				progRdData <= 8'h00;   // [R15]
			end else if (progReq.addr >= CODE_FIRST) begin
				progRdData <= codeRd;   // [R4]
			end else if (progMode_q && progReq.addr == INIT1_PADDR) begin
				progRdData <= nvInit1_q;   // [R13]
			end else if (progMode_q && progReq.addr == INIT2_PADDR) begin
				progRdData <= nvInit2_q;
			end else begin
				progRdData <= 8'h00;
			end
		end
	end

	// Core register writes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			idxHigh_q    <= 8'h00;
			idxLow_q     <= 8'h00;
			pwrModeClr_q <= 8'h00;
			stackPtr_q   <= 8'h00;
			status_q     <= 8'h00;
		end else if (dataReq.wr && dRegion == RG_CORE) begin
			unique case (dataReq.addr)
				IDX_HIGH:     idxHigh_q    <= dataReq.wdata;   // [R3]
				IDX_LOW:      idxLow_q     <= dataReq.wdata;
				PWR_MODE_CLR: pwrModeClr_q <= dataReq.wdata;
				STACK_PTR:    stackPtr_q   <= dataReq.wdata;
				PROC_STATUS:  status_q     <= dataReq.wdata;
				default:      status_q     <= status_q;
			endcase
		end
	end

	// Request stage and peripheral strobes
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dReq_q      <= '0;
			periphRd    <= 1'b0;
			periphWr    <= 1'b0;
			periphAddr  <= 8'h00;
			periphWData <= 8'h00;
		end else begin
			dReq_q      <= dataReq;
			periphRd    <= dataReq.rd && dRegion == RG_PERIPH;   // [R1]
			periphWr    <= dataReq.wr && dRegion == RG_PERIPH;
			periphAddr  <= dataReq.addr;
			periphWData <= dataReq.wdata;
		end
	end

	// Data read answer, two cycles after the request
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dataRdValid <= 1'b0;
			dataRdData  <= 8'h00;
		end else begin
			dataRdValid <= dReq_q.rd;
			if (!dReq_q.rd) begin
				dataRdData <= 8'h00;
			end else begin
				unique case (dRegionQ)
					RG_SRAM:   dataRdData <= sramRd;   // [R2]
					RG_EE:     dataRdData <= eeRd;
					RG_PERIPH: dataRdData <= periphRdData;
					RG_CORE: begin
						unique case (dReq_q.addr)
							IDX_HIGH:     dataRdData <= idxHigh_q;
							IDX_LOW:      dataRdData <= idxLow_q;
							PWR_MODE_CLR: dataRdData <= pwrModeClr_q;
							STACK_PTR:    dataRdData <= stackPtr_q;
							default: begin
								dataRdData <= status_q;
								dataRdData[SR_READY_BIT] <= eeReady;   // [R8]
							end
						endcase
					end
					RG_RSVD:   dataRdData <= 8'h00;   // [R23]
					default:   dataRdData <= 8'h00;
				endcase
			end
		end
	end

	// Configuration outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			configValid         <= 1'b0;
			progModeActive      <= 1'b0;
			clockModeSel        <= 2'h0;
			watchdogEnable      <= 1'b0;
			brownoutEnable      <= 1'b0;
			brownoutLevelSelect <= 1'b0;
			oscTrim             <= 8'h00;
		end else begin
			configValid         <= state_q == ST_RUN;
			progModeActive      <= progMode_q;
			clockModeSel        <= {cfg_q.clkSel1, cfg_q.clkSel0};   // [R14]
			watchdogEnable      <= cfg_q.watchdogEn;                 // [R20]
			brownoutEnable      <= cfg_q.brownoutEn;
			brownoutLevelSelect <= cfg_q.brownoutLvl;
			oscTrim             <= trim_q;                           // [R12]
		end
	end

	// Brown-out reset request
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			brownoutReset <= 1'b0;
		end else begin
			brownoutReset <= cfg_q.brownoutEn && supplyS2_q && state_q == ST_RUN;   // [R19]
		end
	end

	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence fetchSeq;
		state_q == ST_FETCH1 ##1 state_q == ST_FETCH2 ##1 state_q == ST_RUN;
	endsequence

	sequence rsvdRead;
		dataReq.rd && decodeData(dataReq.addr) == RG_RSVD;
	endsequence

	powerup_fetch_a: assert property (state_q == ST_FETCH1 |-> fetchSeq) // [R11]
		else $error("power-up fetch sequence broken");
	reserved_read_a: assert property (rsvdRead |-> ##2 (dataRdValid && dataRdData == 8'h00)) // [R23]
		else $error("reserved read not zero");
	ee_busy_a: assert property (eeAccept |=> !eeReady [*2]) // [R8]
		else $error("ready flag not dropped on write");
	upper_lock_a: assert property (eeAccept |-> !(cfg_q.upperLock && dataReq.addr >= EE_UPPER_FIRST)) // [R17]
		else $error("upper block written while locked");
	code_norm_wr_a: assert property (progReq.wr && !progMode_q |-> !progMemWr) // [R5]
		else $error("code write in normal mode");
	code_lock_wr_a: assert property (progMemWr |-> progMode_q && !cfg_q.writeLock) // [R6]
		else $error("code write while locked");
	read_lock_a: assert property (progReq.rd && progMode_q && cfg_q.readLock
	                              |=> progRdValid && progRdData == 8'h00) // [R15]
		else $error("locked read returned data");
	entry_lock_a: assert property (cfg_q.readLock && cfg_q.writeLock |=> !$rose(progMode_q)) // [R21]
		else $error("programming mode entered while locked");
	brownout_gate_a: assert property (brownoutReset |-> $past(cfg_q.brownoutEn)) // [R19]
		else $error("brown-out reset without enable");
	init_wr_lock_a: assert property (progReq.wr && progReq.addr == INIT1_PADDR && cfg_q.writeLock
	                                 |=> $stable(nvInit1_q)) // [R16]
		else $error("init register written while locked");

endmodule : mmnp_top

// [sim/mmnp_top_bench.sv]
// Self-checking bench for the memory map and nonvolatile protection block.
// Assumes the design package is compiled first and the EEPROM write time is shortened to 8 cycles.
`timescale 1ns/1ps
module mmnp_top_bench;
	import mmnp_pkg::*;

	// Clock, reset and stimulus
	logic        ref_clk;
	logic        rst;
	mmnp_dreq_t  dataReq;
	mmnp_preq_t  progReq;
	logic [7:0]  periphRdData;
	logic        progModePin;
	logic        supplyLowPin;
	// Observed outputs
	logic        dataRdValid, periphRd, periphWr, progRdValid;
	logic [7:0]  dataRdData, periphAddr, periphWData, progRdData, oscTrim;
	logic        progModeActive, configValid, watchdogEnable, brownoutEnable;
	logic        brownoutLevelSelect, brownoutReset;
	logic [1:0]  clockModeSel;
	// Scoreboard
	int          failCount = 0;
	int          totalChecks = 0;
	logic [7:0]  got;
	logic        strobe;
	logic [15:0] seen;
	logic [7:0]  addrs [6];

	// Design under test with a short write cycle
	mmnp_top #(.EE_WRITE_CYCLES(8)) uut (
		.ref_clk(ref_clk), .rst(rst), .dataReq(dataReq), .dataRdValid(dataRdValid),
		.dataRdData(dataRdData), .periphRd(periphRd), .periphWr(periphWr), .periphAddr(periphAddr),
		.periphWData(periphWData), .periphRdData(periphRdData), .progReq(progReq),
		.progRdValid(progRdValid), .progRdData(progRdData), .progModePin(progModePin),
		.supplyLowPin(supplyLowPin), .progModeActive(progModeActive), .configValid(configValid),
		.clockModeSel(clockModeSel), .watchdogEnable(watchdogEnable), .brownoutEnable(brownoutEnable),
		.brownoutLevelSelect(brownoutLevelSelect), .brownoutReset(brownoutReset), .oscTrim(oscTrim)
	);

	// 20 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #25 ref_clk = ~ref_clk;
	end

	// Compare one byte and count it
	task check(input logic [7:0] g, input logic [7:0] e);
		totalChecks++;
		if (g !== e) begin
			failCount++;
			$display("ERROR at %0t ns: got %h expected %h", $time, g, e);
		end
	endtask : check

	// Verdict and end of run
	task completeRun;
		$display("Checks %0d, errors %0d", totalChecks, failCount);
		if (failCount == 0 && totalChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : completeRun

	// Data bus write, keeps the peripheral strobe of the following cycle
	task dataWr(input logic [7:0] a, input logic [7:0] d);
		dataReq = {1'b0, 1'b1, a, d};
		@(negedge ref_clk);
		strobe = periphWr;
		seen = {periphAddr, periphWData};
		dataReq = '0;
		@(negedge ref_clk);
	endtask : dataWr

	// Data bus read with bounded wait for the answer
	task dataRd(input logic [7:0] a, output logic [7:0] g);
		int n;
		dataReq = {1'b1, 1'b0, a, 8'h00};
		@(negedge ref_clk);
		strobe = periphRd;
		dataReq = '0;
		n = 0;
		while (dataRdValid !== 1'b1 && n < 4) begin
			@(negedge ref_clk);
			n++;
		end
		check({7'h00, dataRdValid}, 8'h01);
		g = dataRdData;
		@(negedge ref_clk);
	endtask : dataRd

	// Program bus write
	task progWr(input logic [11:0] a, input logic [7:0] d);
		progReq = {1'b0, 1'b1, a, d};
		@(negedge ref_clk);
		progReq = '0;
		@(negedge ref_clk);
	endtask : progWr

	// Program bus read with bounded wait
	task progRd(input logic [11:0] a, output logic [7:0] g);
		int n;
		progReq = {1'b1, 1'b0, a, 8'h00};
		@(negedge ref_clk);
		progReq = '0;
		n = 0;
		while (progRdValid !== 1'b1 && n < 3) begin
			@(negedge ref_clk);
			n++;
		end
		check({7'h00, progRdValid}, 8'h01);
		g = progRdData;
		@(negedge ref_clk);
	endtask : progRd

	// Poll the status ready flag until a write cycle ends
	task waitReady;
		int n;
		n = 0;
		got = 8'h00;
		while (got[SR_READY_BIT] !== 1'b1 && n < 30) begin
			dataRd(PROC_STATUS, got);
			n++;
		end
		check({7'h00, got[SR_READY_BIT]}, 8'h01);
	endtask : waitReady

	// Drive the programming pin, wait for the mode and a finished init fetch
	task progPin(input logic lvl);
		int n;
		progModePin = lvl;
		n = 0;
		while ((progModeActive !== lvl || configValid !== 1'b1) && n < 12) begin
			@(negedge ref_clk);
			n++;
		end
	endtask : progPin

	// Configuration outputs after the power-up fetch
	task testConfig;
		check({6'h00, clockModeSel}, {6'h00, INIT1_FACTORY[6], INIT1_FACTORY[7]});
		check(oscTrim, INIT2_FACTORY);
		check({4'h0, configValid, watchdogEnable, brownoutEnable, brownoutLevelSelect},
			{4'h0, 1'b1, INIT1_FACTORY[5:3]});
		supplyLowPin = 1'b1;
		repeat (5) @(negedge ref_clk);
		check({7'h00, brownoutReset}, {7'h00, INIT1_FACTORY[4]});
		supplyLowPin = 1'b0;
	endtask : testConfig

	// Scratch RAM edges and the index and stack-pointer core registers hold what is written
	task testStorage;
		addrs = '{8'h00, SRAM_LAST, IDX_HIGH, IDX_LOW, STACK_PTR, 8'h1F};
		foreach (addrs[i]) dataWr(addrs[i], addrs[i] ^ 8'hA5);
		foreach (addrs[i]) begin
			dataRd(addrs[i], got);
			check(got, addrs[i] ^ 8'hA5);
			check({7'h00, strobe}, 8'h00);
		end
	endtask : testStorage

	// Reserved holes read zero and raise no write strobe
	task testReserved;
		addrs = '{8'h80, 8'h9C, 8'hA0, 8'hA9, 8'hB8, 8'hBD};
		foreach (addrs[i]) begin
			dataWr(addrs[i], 8'hFF);
			check({7'h00, strobe}, 8'h00);
			dataRd(addrs[i], got);
			check(got, 8'h00);
		end
	endtask : testReserved

	// Peripheral window strobes and read data pass-through
	task testPeriph;
		addrs = '{CONV_FIRST, CONV_LAST, TMR1_FIRST, 8'hB0, HALT_CTRL, 8'hAE};
		foreach (addrs[i]) begin
			periphRdData = addrs[i] ^ 8'h3C;
			dataRd(addrs[i], got);
			check({7'h00, strobe}, 8'h01);
			check(got, addrs[i] ^ 8'h3C);
			dataWr(addrs[i], 8'h96);
			check({7'h00, strobe}, 8'h01);
			check(seen[15:8], addrs[i]);
			check(seen[7:0], 8'h96);
		end
	endtask : testPeriph

	// Data EEPROM write handshake and busy refusal
	task testEeprom;
		waitReady;
		dataWr(EE_FIRST, 8'h11);
		dataRd(PROC_STATUS, got);
		check({7'h00, got[SR_READY_BIT]}, 8'h00);
		waitReady;
		dataRd(EE_FIRST, got);
		check(got, 8'h11);
		dataWr(EE_LAST, 8'h22);
		dataWr(EE_LAST, 8'h33);
		waitReady;
		dataRd(EE_LAST, got);
		check(got, 8'h22);
	endtask : testEeprom

	// Program space in and out of programming mode
	task testProgram;
		progPin(1'b1);
		check({7'h00, progModeActive}, 8'h01);
		progWr(CODE_FIRST, 8'hA5);
		progWr(VEC_ADC, 8'h5A);
		progRd(CODE_FIRST, got);
		check(got, 8'hA5);
		progRd(VEC_ADC, got);
		check(got, 8'h5A);
		progRd(INIT1_PADDR, got);
		check(got, INIT1_FACTORY);
		progWr(INIT2_PADDR, 8'h81);
		progRd(INIT2_PADDR, got);
		check(got, 8'h81);
		progPin(1'b0);
		check(oscTrim, 8'h81);
		progWr(CODE_FIRST, 8'h3C);
		progRd(CODE_FIRST, got);
		check(got, 8'hA5);
		progRd(INIT1_PADDR, got);
		check(got, 8'h00);
	endtask : testProgram

	// Init register locks, live after the refetch on leaving programming mode
	task testLocks;
		progPin(1'b1);
		progWr(INIT1_PADDR, 8'hBD);
		progPin(1'b0);
		check({6'h00, clockModeSel}, 8'h01);
		check({5'h00, watchdogEnable, brownoutEnable, brownoutLevelSelect}, 8'h07);
		supplyLowPin = 1'b1;
		repeat (4) @(negedge ref_clk);
		check({7'h00, brownoutReset}, 8'h01);
		supplyLowPin = 1'b0;
		waitReady;
		dataWr(EE_LAST, 8'h44);
		waitReady;
		dataRd(EE_LAST, got);
		check(got, 8'h22);
		progPin(1'b1);
		check({7'h00, progModeActive}, 8'h01);
		progRd(CODE_FIRST, got);
		check(got, 8'h00);
		progWr(INIT1_PADDR, 8'h0A);
		progPin(1'b0);
		progPin(1'b1);
		progRd(CODE_FIRST, got);
		check(got, 8'hA5);
		progWr(CODE_FIRST, 8'h77);
		progWr(INIT1_PADDR, 8'h0B);
		progRd(CODE_FIRST, got);
		check(got, 8'hA5);
		progRd(INIT1_PADDR, got);
		check(got, 8'h0A);
		progPin(1'b0);
		rst = 1'b1;
		repeat (2) @(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		check(oscTrim, INIT2_FACTORY);
		progPin(1'b1);
		progWr(INIT1_PADDR, 8'h0B);
		progPin(1'b0);
		progPin(1'b1);
		check({7'h00, progModeActive}, 8'h00);
		progModePin = 1'b0;
	endtask : testLocks

	// Main sequence
	initial begin
		rst = 1'b1;
		dataReq = '0;
		progReq = '0;
		periphRdData = 8'h00;
		progModePin = 1'b0;
		supplyLowPin = 1'b0;
		repeat (5) @(negedge ref_clk);
		rst = 1'b0;
		repeat (3) @(negedge ref_clk);
		testConfig;
		testStorage;
		testReserved;
		testPeriph;
		testEeprom;
		testProgram;
		testLocks;
		completeRun;
	end

	// Hang guard, well beyond the expected run
	initial begin
		#400000;
		failCount++;
		completeRun;
	end

endmodule : mmnp_top_bench
